//--- shared/trf_mon_consts.vh
/*
 * Constants of the transformer state monitor: register byte offsets,
 * field positions, reset values, thresholds and timing counts.
 * Assumes a 25 MHz REF_CLK and 32-bit Avalon-MM registers.
 */
`ifndef LOAD_MON_CONSTS_VH
`define LOAD_MON_CONSTS_VH
// Register byte offsets
`define OFS_CTRL       7'h00
`define OFS_FORCE      7'h04
`define OFS_RATED_S    7'h08
`define OFS_HV_VOLT    7'h0c
`define OFS_LV_VOLT    7'h10
`define OFS_IMP_PCT    7'h14
`define OFS_FREQ       7'h18
`define OFS_VGROUP     7'h1c
`define OFS_STATUS     7'h20
`define OFS_EVENT      7'h24
`define OFS_MASK       7'h28
`define OFS_IN_HV      7'h2c
`define OFS_IN_LV      7'h30
`define OFS_ISC_HV     7'h34
`define OFS_L_SC       7'h38
`define OFS_OVL_TIME   7'h3c
`define OFS_HOVL_TIME  7'h40
// Field positions
`define CTRL_FORCE_EN  0
`define CTRL_EVENT_EN  1
`define CTRL_CNT_CLR   2
`define VG_HV_DELTA    8
// Reset values (settings in 0.1 MVA, 0.1 kV, 0.01 %, 1 Hz)
`define RST_RATED_S    13'h000a
`define RST_VOLT       13'h044c
`define RST_IMP_PCT    12'h12c
`define RST_FREQ       7'h32
`define RST_VGROUP     5'h01
`define VG_LAST        5'h1a
`define VG_FIRST_DHV   5'h10
// Thresholds in tenths of nominal current
`define K_NO_LOAD      4'h2
`define K_NOMINAL      4'ha
`define K_HEAVY        4'hd
// Force codes
`define FORCE_NONE     3'h0
// Timing: no-load qualify time and counter tick, in microseconds
`define CLK_MHZ        25
`define T_NOLOAD_US    10000
`define T_TICK_US      1000
`define NOLOAD_CYC     (`T_NOLOAD_US * `CLK_MHZ)
`define TICK_CYC       (`T_TICK_US * `CLK_MHZ)
`endif

//--- rtl/transformer_state_monitor.v
/*
 * Transformer state monitor: nameplate settings, derived nominal and
 * short-circuit values, load-state classification, force override,
 * cumulative overload timers, sticky events and interrupt.
 * Assumes measurements and shared-setting updates come from logic on
 * REF_CLK, and an Avalon-MM master that holds requests until
 * waitrequest is low.
 */
// Summary of operation
// [RULE1] No-load once per-unit current stays below 0.2 longer than 10 ms
// [RULE2] Rise from no-load above 1.3 sets both HV and LV inrush outputs
// [RULE3] Normal-load while current between no-load limit and nominal
// [RULE4] Overloading while current between nominal and 1.3 times nominal
// [RULE5] Force setting overrides reported state, only when forcing enabled
// [RULE6] HV nominal current from rated power and HV nominal voltage
// [RULE7] LV nominal current from rated power and LV nominal voltage
// [RULE8] Impedance setting in 0.01 % steps gives short-circuit current
// [RULE9] Nominal frequency setting gives short-circuit inductance
// [RULE10] Vector group manual or 1 to 26 with automatic compensation
// [RULE11] Installation wires HV to first input module, LV to second
// [RULE12] HV winding setting writable only in manual vector group
// [RULE13] Edits from other protection functions update shared settings; an edit in the same cycle as an accepted bus write is dropped
// [RULE14] Cumulative overload and high-overcurrent time counters
// [RULE15] Status outputs feed indication and events when enabled
// [RULE16] Thresholds use per-unit current, re-evaluated each measurement
`timescale 1ns/1ns
`include "trf_mon_consts.vh"

module transformer_state_monitor
#(
  parameter NOLOAD_CYC = `NOLOAD_CYC,
  parameter TICK_CYC   = `TICK_CYC
)
(
  // Clock and reset
  input  wire        REF_CLK,
  input  wire        RST,
  // Avalon-MM slave
  input  wire [6:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  // Measurements, one pulse per cycle, currents in amperes
  input  wire        MEAS_VALID,
  input  wire [15:0] MEAS_HV_CUR,
  input  wire [15:0] MEAS_LV_CUR,
  // Shared setting edits from other protection functions
  input  wire        SHARE_WE,
  input  wire [2:0]  SHARE_SEL,
  input  wire [12:0] SHARE_DATA,
  // Shared settings as seen by other functions
  output reg  [12:0] SET_RATED_S,
  output reg  [12:0] SET_HV_VOLT,
  output reg  [12:0] SET_LV_VOLT,
  output reg  [11:0] SET_IMP_PCT,
  // Status outputs
  output reg         NO_LOAD,
  output reg         HV_INRUSH,
  output reg         LV_INRUSH,
  output reg         LOAD_NORMAL,
  output reg         OVERLOAD,
  output reg         HIGH_OVERLOAD,
  // Interrupt
  output reg         IRQ
);

  // Band of a per-unit current: 0 none, 1 normal, 2 over, 3 heavy
  function [1:0] band;
    input [15:0] cur;
    input [31:0] nom;
    reg   [35:0] c10;
    begin
      // Ten times the current, as eight times plus two times
      c10 = {17'h00000, cur, 3'h0} + {19'h00000, cur, 1'b0};
      if (c10 < nom * `K_NO_LOAD)
        band = 2'h0;
      else if (c10 <= nom * `K_NOMINAL)
        band = 2'h1;
      else if (c10 <= nom * `K_HEAVY)
        band = 2'h2;
      else
        band = 2'h3;
    end
  endfunction

  // Settings and control
  reg  [12:0] rated_s;
  reg  [12:0] hv_volt;
  reg  [12:0] lv_volt;
  reg  [11:0] imp_pct;
  reg  [6:0]  freq;
  reg  [4:0]  vgroup;
  reg         hv_delta_man;
  reg         force_en;
  reg         event_en;
  reg  [2:0]  force_code;
  reg  [5:0]  evt;
  reg  [5:0]  mask;
  // Derived values
  reg  [31:0] in_hv;
  reg  [31:0] in_lv;
  reg  [31:0] isc_hv;
  reg  [31:0] l_sc;
  // Divider sequencer
  reg         dirty;
  reg         busy;
  reg  [1:0]  op;
  reg  [5:0]  step;
  reg  [47:0] num;
  reg  [31:0] den;
  reg  [32:0] rem;
  reg  [47:0] quo;
  // Classification
  reg  [1:0]  cur_band;
  reg  [17:0] nl_cnt;
  reg         nl_state;
  reg         inrush;
  reg  [5:0]  status_q;
  reg  [14:0] tick_cnt;
  reg  [31:0] ovl_time;
  reg  [31:0] hovl_time;
  wire [1:0]  load_op = busy ? op + 2'h1 : 2'h0;
  wire        wr_acc = AVS_WRITE & ~AVS_WAITREQUEST;
  wire        cnt_clr = wr_acc & (AVS_ADDRESS == `OFS_CTRL)
                        & AVS_WRITEDATA[`CTRL_CNT_CLR];
  wire [1:0]  band_hv = band(MEAS_HV_CUR, in_hv);
  wire [1:0]  band_lv = band(MEAS_LV_CUR, in_lv);
  wire        hv_delta;
  reg  [5:0]  next_status;
  reg  [47:0] next_num;
  reg  [31:0] next_den;
  wire [32:0] rem_sh = {rem[31:0], num[47]};

  // [RULE10] Predefined groups pick winding from their code
  assign hv_delta = (vgroup == 5'h00) ? hv_delta_man
                                      : (vgroup >= `VG_FIRST_DHV);

  // Bus handshake: one wait cycle, then access at the low edge
  always @(posedge REF_CLK)
  begin
    if (RST)
      AVS_WAITREQUEST <= 1'b1;
    else if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST)
      AVS_WAITREQUEST <= 1'b0;
    else
      AVS_WAITREQUEST <= 1'b1;
  end

  // Read data prepared during the wait cycle
  always @(posedge REF_CLK)
  begin
    if (RST)
      AVS_READDATA <= 32'h00000000;
    else if (AVS_READ & AVS_WAITREQUEST)
    begin
      case (AVS_ADDRESS)
        `OFS_CTRL:      AVS_READDATA <= {30'h0, event_en, force_en};
        `OFS_FORCE:     AVS_READDATA <= {29'h0, force_code};
        `OFS_RATED_S:   AVS_READDATA <= {19'h0, rated_s};
        `OFS_HV_VOLT:   AVS_READDATA <= {19'h0, hv_volt};
        `OFS_LV_VOLT:   AVS_READDATA <= {19'h0, lv_volt};
        `OFS_IMP_PCT:   AVS_READDATA <= {20'h0, imp_pct};
        `OFS_FREQ:      AVS_READDATA <= {25'h0, freq};
        `OFS_VGROUP:    AVS_READDATA <= {23'h0, hv_delta, 3'h0, vgroup};
        `OFS_STATUS:    AVS_READDATA <= {25'h0, busy | dirty, status_q};
        `OFS_EVENT:     AVS_READDATA <= {26'h0, evt};
        `OFS_MASK:      AVS_READDATA <= {26'h0, mask};
        `OFS_IN_HV:     AVS_READDATA <= in_hv;
        `OFS_IN_LV:     AVS_READDATA <= in_lv;
        `OFS_ISC_HV:    AVS_READDATA <= isc_hv;
        `OFS_L_SC:      AVS_READDATA <= l_sc;
        `OFS_OVL_TIME:  AVS_READDATA <= ovl_time;
        `OFS_HOVL_TIME: AVS_READDATA <= hovl_time;
        default:        AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  // Setting registers, written by software or by shared edits
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rated_s      <= `RST_RATED_S;
      hv_volt      <= `RST_VOLT;
      lv_volt      <= `RST_VOLT;
      imp_pct      <= `RST_IMP_PCT;
      freq         <= `RST_FREQ;
      vgroup       <= `RST_VGROUP;
      hv_delta_man <= 1'b0;
      force_en     <= 1'b0;
      event_en     <= 1'b0;
      force_code   <= `FORCE_NONE;
      mask         <= 6'h00;
      dirty        <= 1'b1;
    end
    else
    begin
      if (wr_acc)
      begin
        dirty <= 1'b1;
        case (AVS_ADDRESS)
          `OFS_CTRL:
          begin
            force_en <= AVS_WRITEDATA[`CTRL_FORCE_EN];
            event_en <= AVS_WRITEDATA[`CTRL_EVENT_EN];
          end
          `OFS_FORCE:   force_code <= AVS_WRITEDATA[2:0];
          `OFS_RATED_S: rated_s <= AVS_WRITEDATA[12:0];
          `OFS_HV_VOLT: hv_volt <= AVS_WRITEDATA[12:0];
          `OFS_LV_VOLT: lv_volt <= AVS_WRITEDATA[12:0];
          // [RULE8] Impedance in 0.01 % steps
          `OFS_IMP_PCT: imp_pct <= AVS_WRITEDATA[11:0];
          // [RULE9] Frequency in 1 Hz steps
          `OFS_FREQ:    freq <= AVS_WRITEDATA[6:0];
          `OFS_VGROUP:
          begin
            // [RULE10] Codes above the table are ignored
            if (AVS_WRITEDATA[4:0] <= `VG_LAST)
              vgroup <= AVS_WRITEDATA[4:0];
            // [RULE12] Winding only editable in manual
            if (vgroup == 5'h00)
              hv_delta_man <= AVS_WRITEDATA[`VG_HV_DELTA];
          end
          `OFS_MASK:    mask <= AVS_WRITEDATA[5:0];
          default:      dirty <= 1'b1;
        endcase
      end
      // [RULE13] Shared edits land in the same registers
      else if (SHARE_WE)
      begin
        dirty <= 1'b1;
        case (SHARE_SEL)
          3'h0:    rated_s <= SHARE_DATA;
          3'h1:    hv_volt <= SHARE_DATA;
          3'h2:    lv_volt <= SHARE_DATA;
          3'h3:    imp_pct <= SHARE_DATA[11:0];
          3'h4:    freq <= SHARE_DATA[6:0];
          default: dirty <= 1'b1;
        endcase
      end
      else if (!busy)
        dirty <= 1'b0;
    end
  end

  // Operands of each derivation step
  always @*
  begin
    next_num = 48'h0;
    next_den = 32'h0;
    // Operands belong to the step about to be loaded, not the current one
    case (load_op)
      // [RULE6] HV nominal current, amperes
      2'h0:
      begin
        next_num = {35'h0, rated_s} * 48'd1000000;
        next_den = {19'h0, hv_volt} * 32'd1732;
      end
      // [RULE7] LV nominal current, amperes
      2'h1:
      begin
        next_num = {35'h0, rated_s} * 48'd1000000;
        next_den = {19'h0, lv_volt} * 32'd1732;
      end
      // [RULE8] Short-circuit current from impedance
      2'h2:
      begin
        next_num = {16'h0, in_hv} * 48'd10000;
        next_den = {20'h0, imp_pct};
      end
      // [RULE9] Short-circuit inductance, microhenry
      default:
      begin
        next_num = {36'h0, imp_pct} * {35'h0, hv_volt} * {35'h0, hv_volt}
                   * 48'd1000;
        next_den = {19'h0, rated_s} * {25'h0, freq} * 32'd628;
      end
    endcase
  end

  // Restoring divider walking through the four derivations
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      busy   <= 1'b0;
      op     <= 2'h0;
      step   <= 6'h00;
      num    <= 48'h0;
      den    <= 32'h0;
      rem    <= 33'h0;
      quo    <= 48'h0;
      in_hv  <= 32'h0;
      in_lv  <= 32'h0;
      isc_hv <= 32'h0;
      l_sc   <= 32'h0;
    end
    else if (!busy)
    begin
      if (dirty)
      begin
        busy <= 1'b1;
        op   <= 2'h0;
        step <= 6'h00;
        num  <= next_num;
        den  <= next_den;
        rem  <= 33'h0;
      end
    end
    else if (step != 6'd48)
    begin
      num  <= {num[46:0], 1'b0};
      step <= step + 6'h01;
      if (rem_sh >= {1'b0, den})
      begin
        rem <= rem_sh - {1'b0, den};
        quo <= {quo[46:0], 1'b1};
      end
      else
      begin
        rem <= rem_sh;
        quo <= {quo[46:0], 1'b0};
      end
    end
    else
    begin
      case (op)
        2'h0:    in_hv <= (quo[47:32] != 16'h0) ? 32'hffffffff : quo[31:0];
        2'h1:    in_lv <= (quo[47:32] != 16'h0) ? 32'hffffffff : quo[31:0];
        2'h2:    isc_hv <= (quo[47:32] != 16'h0) ? 32'hffffffff : quo[31:0];
        default: l_sc <= (quo[47:32] != 16'h0) ? 32'hffffffff : quo[31:0];
      endcase
      step <= 6'h00;
      rem  <= 33'h0;
      op   <= op + 2'h1;
      busy <= (op != 2'h3);
      num  <= next_num;
      den  <= next_den;
    end
  end

  // [RULE16] Band taken at each measurement cycle, worse side wins
  always @(posedge REF_CLK)
  begin
    if (RST)
      cur_band <= 2'h1;
    else if (MEAS_VALID)
      cur_band <= (band_hv > band_lv) ? band_hv : band_lv;
  end

  // [RULE1] No-load after 10 ms below limit; [RULE2] inrush latch
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      nl_cnt   <= 18'h0;
      nl_state <= 1'b0;
      inrush   <= 1'b0;
    end
    else
    begin
      if (cur_band != 2'h0)
        nl_cnt <= 18'h0;
      else if (nl_cnt <= NOLOAD_CYC[17:0])
        nl_cnt <= nl_cnt + 18'h1;
      if (cur_band == 2'h0)
        nl_state <= (nl_cnt > NOLOAD_CYC[17:0]) | nl_state;
      else
        nl_state <= 1'b0;
      if (cur_band != 2'h3)
        inrush <= 1'b0;
      else if (nl_state)
        inrush <= 1'b1;
    end
  end

  // Measured state, then the force override
  always @*
  begin
    next_status = 6'h00;
    // [RULE1] No-load while qualified and still in the lowest band
    next_status[0] = nl_state & (cur_band == 2'h0);
    // [RULE2] Inrush shown from the first heavy band after no-load
    next_status[1] = inrush | (nl_state & (cur_band == 2'h3));
    next_status[2] = inrush | (nl_state & (cur_band == 2'h3));
    next_status[3] = (cur_band == 2'h1);
    next_status[4] = (cur_band == 2'h2);
    next_status[5] = (cur_band == 2'h3) & ~inrush & ~nl_state;
    // [RULE5] Forced code replaces the state
    if (force_en && force_code != `FORCE_NONE && force_code <= 3'h6)
      next_status = 6'h01 << (force_code - 3'h1);
  end

  // [RULE15] Status outputs and their event sources
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      status_q      <= 6'h00;
      NO_LOAD       <= 1'b0;
      HV_INRUSH     <= 1'b0;
      LV_INRUSH     <= 1'b0;
      LOAD_NORMAL   <= 1'b0;
      OVERLOAD      <= 1'b0;
      HIGH_OVERLOAD <= 1'b0;
    end
    else
    begin
      status_q      <= next_status;
      NO_LOAD       <= next_status[0];
      HV_INRUSH     <= next_status[1];
      LV_INRUSH     <= next_status[2];
      LOAD_NORMAL   <= next_status[3];
      OVERLOAD      <= next_status[4];
      HIGH_OVERLOAD <= next_status[5];
    end
  end

  // Sticky events on each rising status bit while event_en is set; set wins over clear
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      evt <= 6'h00;
      IRQ <= 1'b0;
    end
    else
    begin
      evt <= (evt & ~((wr_acc && AVS_ADDRESS == `OFS_EVENT)
                      ? AVS_WRITEDATA[5:0] : 6'h00))
             | ((next_status & ~status_q) & {6{event_en}});
      IRQ <= |(evt & mask);
    end
  end

  // [RULE14] Millisecond counts of overload and high overcurrent
  always @(posedge REF_CLK)
  begin
    if (RST || cnt_clr)
    begin
      tick_cnt  <= 15'h0;
      ovl_time  <= 32'h0;
      hovl_time <= 32'h0;
    end
    else if (tick_cnt == TICK_CYC[14:0] - 15'h1)
    begin
      tick_cnt <= 15'h0;
      if (status_q[4] && ovl_time != 32'hffffffff)
        ovl_time <= ovl_time + 32'h1;
      if (status_q[5] && hovl_time != 32'hffffffff)
        hovl_time <= hovl_time + 32'h1;
    end
    else
      tick_cnt <= tick_cnt + 15'h1;
  end

  // Shared settings to other functions
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      SET_RATED_S <= `RST_RATED_S;
      SET_HV_VOLT <= `RST_VOLT;
      SET_LV_VOLT <= `RST_VOLT;
      SET_IMP_PCT <= `RST_IMP_PCT;
    end
    else
    begin
      SET_RATED_S <= rated_s;
      SET_HV_VOLT <= hv_volt;
      SET_LV_VOLT <= lv_volt;
      SET_IMP_PCT <= imp_pct;
    end
  end

endmodule // transformer_state_monitor

//--- test/trf_mon_asserts.sv
/*
 * Checker for the transformer state monitor: bus handshake, status
 * outputs and shared settings.
 * Assumes it is bound to the monitor top and sees only its ports.
 */
`timescale 1ns/1ns
`include "trf_mon_consts.vh"

module load_mon_asserts
(
  // Clock and reset
  input wire        REF_CLK,
  input wire        RST,
  // Register bus
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire        AVS_WAITREQUEST,
  // Shared edits and copies
  input wire        SHARE_WE,
  input wire [2:0]  SHARE_SEL,
  input wire [12:0] SHARE_DATA,
  input wire [12:0] SET_RATED_S,
  input wire [12:0] SET_HV_VOLT,
  // Status and interrupt
  input wire        NO_LOAD,
  input wire        HV_INRUSH,
  input wire        LOAD_NORMAL,
  input wire        OVERLOAD,
  input wire        HIGH_OVERLOAD,
  input wire        IRQ
);
  reg [12:0] last_share;
  wire       bus_wr_done;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // Bus write completing wins over a shared edit
  assign bus_wr_done = AVS_WRITE && !AVS_WAITREQUEST;

  // Last value offered by another function
  always @(posedge REF_CLK)
    if (SHARE_WE)
      last_share <= SHARE_DATA;

  reset_values_a: assert property (
    $past(RST) |-> SET_RATED_S == `RST_RATED_S && SET_HV_VOLT == `RST_VOLT
      && !IRQ && AVS_WAITREQUEST)
    else $error("settings not at defaults after reset");
  wait_answer_a: assert property (
    $rose(AVS_READ) || $rose(AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  wait_idle_a: assert property (
    !AVS_READ && !AVS_WRITE |-> AVS_WAITREQUEST)
    else $error("waitrequest low without a request");
  status_excl_a: assert property (
    $onehot0({NO_LOAD, LOAD_NORMAL, OVERLOAD, HIGH_OVERLOAD}))
    else $error("more than one load state reported");
  inrush_heavy_a: assert property (HV_INRUSH |-> !HIGH_OVERLOAD)
    else $error("high overload shown during inrush");
  share_rated_a: assert property (
    SHARE_WE && SHARE_SEL == 3'h0 && !bus_wr_done
      |-> ##[1:3] SET_RATED_S == last_share)
    else $error("shared rated power edit not applied");
  share_hv_a: assert property (
    SHARE_WE && SHARE_SEL == 3'h1 && !bus_wr_done
      |-> ##[1:3] SET_HV_VOLT == last_share)
    else $error("shared HV voltage edit not applied");
endmodule // load_mon_asserts

bind transformer_state_monitor load_mon_asserts i_chk
(
  .REF_CLK(REF_CLK), .RST(RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .SHARE_WE(SHARE_WE), .SHARE_SEL(SHARE_SEL), .SHARE_DATA(SHARE_DATA),
  .SET_RATED_S(SET_RATED_S), .SET_HV_VOLT(SET_HV_VOLT),
  .NO_LOAD(NO_LOAD), .HV_INRUSH(HV_INRUSH), .LOAD_NORMAL(LOAD_NORMAL),
  .OVERLOAD(OVERLOAD), .HIGH_OVERLOAD(HIGH_OVERLOAD), .IRQ(IRQ)
);

//--- test/test_transformer_state_monitor.sv
/*
 * Self-checking bench of the transformer state monitor.
 * Assumes short no-load and tick counts; the bench drives all ports.
 */
`timescale 1ns/1ns
`include "trf_mon_consts.vh"

module test_transformer_state_monitor;
  reg         REF_CLK, RST, AVS_READ, AVS_WRITE, MEAS_VALID, SHARE_WE;
  reg  [6:0]  AVS_ADDRESS;
  reg  [31:0] AVS_WRITEDATA, rd, nom;
  reg  [15:0] MEAS_HV_CUR, MEAS_LV_CUR, cur;
  reg  [2:0]  SHARE_SEL;
  reg  [12:0] SHARE_DATA, lv;
  wire [31:0] AVS_READDATA;
  wire [12:0] SET_HV_VOLT, SET_LV_VOLT;
  wire [11:0] SET_IMP_PCT;
  wire [5:0]  stat;
  wire        AVS_WAITREQUEST, IRQ;
  integer     miscompares, checked, seed, k;

  transformer_state_monitor #(.NOLOAD_CYC(20), .TICK_CYC(10)) i_dut
  (
    .REF_CLK(REF_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .MEAS_VALID(MEAS_VALID),
    .MEAS_HV_CUR(MEAS_HV_CUR), .MEAS_LV_CUR(MEAS_LV_CUR),
    .SHARE_WE(SHARE_WE), .SHARE_SEL(SHARE_SEL), .SHARE_DATA(SHARE_DATA),
    .SET_RATED_S(), .SET_HV_VOLT(SET_HV_VOLT), .SET_LV_VOLT(SET_LV_VOLT),
    .SET_IMP_PCT(SET_IMP_PCT),
    .NO_LOAD(stat[0]), .HV_INRUSH(stat[1]), .LV_INRUSH(stat[2]),
    .LOAD_NORMAL(stat[3]), .OVERLOAD(stat[4]), .HIGH_OVERLOAD(stat[5]),
    .IRQ(IRQ)
  );

  // Clock at 25 MHz
  initial
  begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  task wrap_up;
  begin
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  task check_reg(input [8*10-1:0] name, input [31:0] exp, input [31:0] got);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      miscompares = miscompares + 1;
    end
  end
  endtask

  task chkpins(input [8*10-1:0] name, input [5:0] exp, input [5:0] got);
  begin
    check_reg(name, {26'h0, exp}, {26'h0, got});
  end
  endtask

  // One bus access, held until waitrequest is sampled low
  task bus(input wr, input [6:0] a, input [31:0] d);
    integer n;
  begin
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    @(posedge REF_CLK);
    while (AVS_WAITREQUEST !== 1'b0 && n < 50)
    begin
      @(posedge REF_CLK);
      n = n + 1;
    end
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (AVS_WAITREQUEST !== 1'b0)
    begin
      miscompares = miscompares + 1;
      wrap_up;
    end
    @(posedge REF_CLK);
  end
  endtask

  task rdchk(input [8*10-1:0] name, input [6:0] a, input [31:0] exp);
  begin
    bus(1'b0, a, 32'h0);
    check_reg(name, exp, rd);
  end
  endtask

  // Wait until derivation of nominal values is done
  task idle;
    integer n;
  begin
    n = 0;
    rd = 32'h40;
    while (rd[6] !== 1'b0 && n < 400)
    begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      n = n + 1;
    end
    check_reg("busy", 32'h0, {31'h0, rd[6]});
    if (rd[6] !== 1'b0)
      wrap_up;
  end
  endtask

  // One measurement, outputs settle two edges later
  task meas(input [15:0] h);
  begin
    MEAS_HV_CUR <= h;
    MEAS_LV_CUR <= 16'h0;
    MEAS_VALID <= 1'b1;
    @(posedge REF_CLK);
    MEAS_VALID <= 1'b0;
    repeat (3) @(posedge REF_CLK);
  end
  endtask

  task share(input [2:0] s, input [12:0] d);
  begin
    SHARE_SEL <= s;
    SHARE_DATA <= d;
    SHARE_WE <= 1'b1;
    @(posedge REF_CLK);
    SHARE_WE <= 1'b0;
    repeat (3) @(posedge REF_CLK);
  end
  endtask

  function [31:0] nomcur(input [63:0] s, input [63:0] u);
    nomcur = 32'(s * 64'd1000000 / (u * 64'd1732));
  endfunction

  function [5:0] band(input [31:0] c, input [31:0] n);
    if (c * 10 < 2 * n)
      band = 6'h01;
    else if (c * 10 <= 10 * n)
      band = 6'h08;
    else if (c * 10 <= 13 * n)
      band = 6'h10;
    else
      band = 6'h20;
  endfunction

  // Main sequence
  initial
  begin
    seed = 60;
    miscompares = 0;
    checked = 0;
    RST = 1'b1;
    AVS_ADDRESS = 7'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    MEAS_VALID = 1'b0;
    MEAS_HV_CUR = 16'h0;
    MEAS_LV_CUR = 16'h0;
    SHARE_WE = 1'b0;
    SHARE_SEL = 3'h0;
    SHARE_DATA = 13'h0;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    idle;
    rdchk("rated_s", `OFS_RATED_S, `RST_RATED_S);
    rdchk("lv_volt", `OFS_LV_VOLT, `RST_VOLT);
    rdchk("imp_pct", `OFS_IMP_PCT, `RST_IMP_PCT);
    rdchk("freq", `OFS_FREQ, `RST_FREQ);
    rdchk("in_hv", `OFS_IN_HV, nomcur(10, 1100));
    rdchk("unmapped", 7'h7c, 32'h0);
    lv = 13'd50 + 13'({$random(seed)} % 1000);
    bus(1'b1, `OFS_RATED_S, 32'd100);
    bus(1'b1, `OFS_HV_VOLT, 32'd110);
    bus(1'b1, `OFS_LV_VOLT, {19'h0, lv});
    idle;
    nom = nomcur(100, 110);
    rdchk("in_hv", `OFS_IN_HV, nom);
    rdchk("in_lv", `OFS_IN_LV, nomcur(100, {51'h0, lv}));
    rdchk("isc_hv", `OFS_ISC_HV, nom * 10000 / `RST_IMP_PCT);
    cur = 16'(64'd12100000 * `RST_IMP_PCT / (62800 * `RST_FREQ));
    rdchk("l_sc", `OFS_L_SC, {16'h0, cur});
    meas(16'd300);
    for (k = 0; k < 24; k = k + 1)
    begin
      case (k)
        0: cur = nom[15:0];
        1: cur = nom[15:0] + 16'd1;
        2: cur = 16'(nom * 13 / 10);
        3: cur = 16'(nom * 13 / 10 + 1);
        default: cur = 16'(120 + {$random(seed)} % 900);
      endcase
      meas(cur);
      chkpins("status", band({16'h0, cur}, nom), stat);
    end
    meas(16'd0);
    repeat (12) @(posedge REF_CLK);
    chkpins("no_load", 6'h00, {5'h00, stat[0]});
    k = 0;
    while (stat[0] !== 1'b1 && k < 40)
    begin
      @(posedge REF_CLK);
      k = k + 1;
    end
    chkpins("no_load", 6'h01, stat);
    if (stat[0] !== 1'b1)
      wrap_up;
    meas(16'd2000);
    chkpins("inrush", 6'h06, stat);
    meas(16'd300);
    bus(1'b1, `OFS_CTRL, 32'h1);
    for (k = 1; k < 7; k = k + 1)
    begin
      bus(1'b1, `OFS_FORCE, k);
      repeat (3) @(posedge REF_CLK);
      chkpins("forced", 6'h01 << (k - 1), stat);
    end
    bus(1'b1, `OFS_CTRL, 32'h0);
    bus(1'b1, `OFS_FORCE, 32'h5);
    repeat (3) @(posedge REF_CLK);
    chkpins("unforced", 6'h08, stat);
    bus(1'b1, `OFS_CTRL, 32'h2);
    bus(1'b1, `OFS_MASK, 32'h0);
    bus(1'b1, `OFS_EVENT, 32'h3f);
    idle;
    meas(16'd600);
    meas(16'd300);
    rdchk("event", `OFS_EVENT, 32'h18);
    chkpins("irq", 6'h00, {5'h00, IRQ});
    bus(1'b1, `OFS_MASK, 32'h8);
    repeat (2) @(posedge REF_CLK);
    chkpins("irq", 6'h01, {5'h00, IRQ});
    bus(1'b1, `OFS_EVENT, 32'h8);
    repeat (2) @(posedge REF_CLK);
    chkpins("irq", 6'h00, {5'h00, IRQ});
    rdchk("event", `OFS_EVENT, 32'h10);
    bus(1'b1, `OFS_CTRL, 32'h4);
    idle;
    meas(16'd600);
    repeat (100) @(posedge REF_CLK);
    meas(16'd2000);
    repeat (50) @(posedge REF_CLK);
    meas(16'd300);
    bus(1'b0, `OFS_OVL_TIME, 32'h0);
    check_reg("ovl_time", 32'h1, {31'h0, rd >= 9 && rd <= 11});
    bus(1'b0, `OFS_HOVL_TIME, 32'h0);
    check_reg("hovl_time", 32'h1, {31'h0, rd >= 4 && rd <= 6});
    bus(1'b1, `OFS_VGROUP, 32'd27);
    rdchk("vgroup", `OFS_VGROUP, 32'h1);
    bus(1'b1, `OFS_VGROUP, 32'h0);
    bus(1'b1, `OFS_VGROUP, 32'h100);
    rdchk("vgroup", `OFS_VGROUP, 32'h100);
    bus(1'b1, `OFS_VGROUP, 32'h105);
    rdchk("vgroup", `OFS_VGROUP, 32'h5);
    bus(1'b1, `OFS_VGROUP, 32'h10);
    rdchk("vgroup", `OFS_VGROUP, 32'h110);
    share(3'h1, 13'd1000);
    rdchk("hv_volt", `OFS_HV_VOLT, 32'd1000);
    check_reg("set_hv", 32'd1000, {19'h0, SET_HV_VOLT});
    share(3'h0, 13'd200);
    rdchk("rated_s", `OFS_RATED_S, 32'd200);
    share(3'h2, 13'd330);
    check_reg("set_lv", 32'd330, {19'h0, SET_LV_VOLT});
    share(3'h3, 13'd450);
    check_reg("set_imp", 32'd450, {20'h0, SET_IMP_PCT});
    wrap_up;
  end
endmodule // test_transformer_state_monitor
